// >>> rtl/pb_power_sequencer.v
// Push-button power sequencer: rail enables, manual reset, button status, interrupt output.
// Assumes comparator results and host pins arrive asynchronously; registers on a plain port.
//
// Contract
// - Resistive button press and direct manual reset are told apart; only direct resets.
// - Direct press drives reset low at once, held until release and timeout expiry.
// - Button-status output is driven low while the button is pressed, else released.
// - Reset output low at startup until timeout after io rail power-good.
// - Interrupt output driven low while any unmasked interrupt condition is present.
// - Interrupt sources reset masked; software unmasks each one through registers.
// - Enable order: io buck, oscillator LDO, core buck, memory buck, usb LDO.
// - At io power-good, oscillator LDO enables and reset output asserts together.
// - Core at 2ms, memory at 4ms, usb at 8ms after io power-good.
// - Actual delays may lie within (T-1ms)*88% to T*112% of typical.
// - Reset released at timer expiry only if io rail is still power-good.
// - Button released before hold and hibernate-high: boot ends, all rails off except a memory buck kept on by the force flag.
// - Force flag set keeps memory buck on without power-hold.
// - From hibernate a press enables rails; io good starts core and reset timer.
// - Button enables five rails; hold keeps memory buck; hibernate-low keeps others.
// - Hibernate: hold, hibernate-low low, force flag set; only memory buck stays on.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "pb_seq_defines.vh"
module pb_power_sequencer #(
    parameter [15:0] RST_TIMEOUT_MS = `RST_TIMEOUT_MS_DEFAULT,
    parameter [23:0] MS_CYCLES = `MS_CYCLES
) (
    input wire clk,
    input wire resetn,
    input wire button_press_in,
    input wire manual_reset_in,
    input wire power_hold,
    input wire hibernate_low,
    input wire io_power_good,
    input wire sys_level_status_n,
    input wire fault_in,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output wire reset_out_n_o,
    output wire reset_out_n_oe,
    output wire button_status_out_o,
    output wire button_status_out_oe,
    output wire interrupt_out_n_o,
    output wire interrupt_out_n_oe,
    output reg memory_buck_en,
    output reg io_buck_en,
    output reg core_buck_en,
    output reg oscillator_ldo_en,
    output reg usb_ldo_en,
    output reg aux_ldo_a_en,
    output reg aux_ldo_b_en
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers.

localparam NSYNC = 7;
reg [NSYNC-1:0] sync1_q;
reg [NSYNC-1:0] sync2_q;
wire [NSYNC-1:0] async_in;
assign async_in = {fault_in, sys_level_status_n, io_power_good, hibernate_low,
                   power_hold, manual_reset_in, button_press_in};

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        sync1_q <= 7'h00;
        sync2_q <= 7'h00;
    end else begin
        sync1_q <= async_in;
        sync2_q <= sync1_q;
    end
end

wire press_s = sync2_q[0] | sync2_q[1];
wire mreset_s = sync2_q[1];
wire hold_s = sync2_q[2];
wire hib_high_s = sync2_q[3];
wire io_good_s = sync2_q[4];
wire sys_low_s = sync2_q[5];
wire fault_s = sync2_q[6];

////////////////////////////////////////////////////////////////////////////////
// Registers.

reg [7:0] ctrl_q;
reg [7:0] mask_q;
wire frc_on = ctrl_q[`CTRL_FRC_BIT];
wire ctrl_we = reg_wr && (reg_addr == `REG_CTRL);
wire mask_we = reg_wr && (reg_addr == `REG_IRQ_MASK);

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        ctrl_q <= `CTRL_RESET;
    end else if (ctrl_we) begin
        ctrl_q <= reg_wdata;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        mask_q <= `MASK_RESET;
    end else if (mask_we) begin
        mask_q <= reg_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer state machine.

localparam S_OFF = 5'h01;
localparam S_WAIT_IO = 5'h02;
localparam S_BOOT = 5'h04;
localparam S_ON = 5'h08;
localparam S_HIB = 5'h10;

localparam MS_W = 24;
localparam [MS_W-1:0] MS_LAST = MS_CYCLES - 24'h000001;
localparam [7:0] T_CORE = `T_CORE_MS;
localparam [7:0] T_MEM = `T_MEM_MS;
localparam [7:0] T_USB = `T_USB_MS;
localparam [15:0] T_RST = RST_TIMEOUT_MS;

reg [4:0] state_q;
reg [4:0] state_d;
reg wake_q;
reg [MS_W-1:0] tick_cnt_q;
reg [7:0] seq_ms_q;
reg [15:0] rst_ms_q;
reg rst_run_q;
reg reset_low_q;
wire ms_tick = (tick_cnt_q == MS_LAST);
wire rst_expired = rst_run_q && (rst_ms_q >= T_RST);
// Hold together with hibernate-low high means the host has taken over the rails.
wire host_holds = hold_s & hib_high_s;

always @* begin
    state_d = state_q;
    case (state_q)
        S_OFF: begin
            if (press_s)
                state_d = S_WAIT_IO;
        end
        S_WAIT_IO: begin
            if (!press_s && !host_holds)
                state_d = S_OFF;
            else if (io_good_s)
                state_d = S_BOOT;
        end
        S_BOOT: begin
            if (!press_s && !host_holds)
                state_d = frc_on ? S_HIB : S_OFF;
            else if (host_holds && !press_s)
                state_d = S_ON;
        end
        S_ON: begin
            if (!hib_high_s)
                state_d = (hold_s || frc_on) ? S_HIB : S_OFF;
        end
        S_HIB: begin
            if (press_s)
                state_d = S_WAIT_IO;
            else if (!hold_s && !frc_on)
                state_d = S_OFF;
        end
        default: state_d = S_OFF;
    endcase
end

wire timer_phase = (state_q == S_BOOT) || (state_q == S_ON);

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        state_q <= S_OFF;
    end else begin
        state_q <= state_d;
    end
end

// The wake flag marks a boot that started in hibernate, so core, memory and usb rails come up with the oscillator LDO.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        wake_q <= 1'b0;
    end else if (state_q == S_HIB) begin
        wake_q <= 1'b1;
    end else if (state_q == S_OFF || state_q == S_ON) begin
        wake_q <= 1'b0;
    end
end

// The timebase starts at power-good and keeps running in on, so a manual reset can time out.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        tick_cnt_q <= 24'h000000;
    end else if (!timer_phase || ms_tick) begin
        tick_cnt_q <= 24'h000000;
    end else begin
        tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        seq_ms_q <= 8'h00;
    end else if (state_q != S_BOOT) begin
        seq_ms_q <= 8'h00;
    end else if (ms_tick && seq_ms_q != 8'hFF) begin
        seq_ms_q <= seq_ms_q + 8'h01;
    end
end

// A direct press holds the timer at zero, so the timeout is counted from the release.
// The first millisecond after a release may be partial; that loss stays within the tolerance.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rst_run_q <= 1'b0;
        rst_ms_q <= 16'h0000;
    end else if (!timer_phase) begin
        rst_run_q <= 1'b0;
        rst_ms_q <= 16'h0000;
    end else if (mreset_s) begin
        rst_run_q <= 1'b1;
        rst_ms_q <= 16'h0000;
    end else begin
        rst_run_q <= 1'b1;
        if (ms_tick && !rst_expired)
            rst_ms_q <= rst_ms_q + 16'h0001;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        reset_low_q <= 1'b1;
    end else if (!timer_phase) begin
        reset_low_q <= 1'b1;
    end else if (mreset_s) begin
        reset_low_q <= 1'b1;
    end else if (rst_expired && io_good_s) begin
        reset_low_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Rail enables.

wire seq_phase = (state_q == S_BOOT);
wire run_phase = (state_q == S_ON);
wire io_buck_d = (state_q == S_WAIT_IO) || seq_phase || run_phase;
wire oscillator_ldo_d = seq_phase || run_phase;
wire core_buck_d = (seq_phase && (wake_q || seq_ms_q >= T_CORE)) || run_phase;
wire usb_ldo_d = (seq_phase && (wake_q || seq_ms_q >= T_USB)) || run_phase;
// The force flag keeps the memory rail up in every state until software clears it.
wire memory_buck_d = (seq_phase && (wake_q || seq_ms_q >= T_MEM)) || run_phase
                     || (state_q == S_HIB) || frc_on;

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        io_buck_en <= 1'b0;
        oscillator_ldo_en <= 1'b0;
        core_buck_en <= 1'b0;
        memory_buck_en <= 1'b0;
        usb_ldo_en <= 1'b0;
        aux_ldo_a_en <= 1'b0;
        aux_ldo_b_en <= 1'b0;
    end else begin
        io_buck_en <= io_buck_d;
        oscillator_ldo_en <= oscillator_ldo_d;
        core_buck_en <= core_buck_d;
        memory_buck_en <= memory_buck_d;
        usb_ldo_en <= usb_ldo_d;
        aux_ldo_a_en <= run_phase && ctrl_q[`CTRL_AUXA_BIT];
        aux_ldo_b_en <= run_phase && ctrl_q[`CTRL_AUXB_BIT];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Open-drain outputs and interrupt.

reg irq_q;
reg bstat_q;
wire sys_pend = sys_low_s & mask_q[`MASK_SYS_BIT];
wire flt_pend = fault_s & mask_q[`MASK_FLT_BIT];

// The interrupt follows its sources as a level; nothing is latched, so software reads status.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        irq_q <= 1'b0;
    end else begin
        irq_q <= sys_pend | flt_pend;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        bstat_q <= 1'b0;
    end else begin
        bstat_q <= press_s;
    end
end

assign reset_out_n_o = 1'b0;
assign reset_out_n_oe = reset_low_q;
assign button_status_out_o = 1'b0;
assign button_status_out_oe = bstat_q;
assign interrupt_out_n_o = 1'b0;
assign interrupt_out_n_oe = irq_q;

////////////////////////////////////////////////////////////////////////////////
// Read port; data valid in the cycle after the strobe.

reg [7:0] rdata_d;
always @* begin
    rdata_d = 8'h00;
    if (reg_rd) begin
        case (reg_addr)
            `REG_CTRL: rdata_d = ctrl_q;
            `REG_IRQ_MASK: rdata_d = mask_q;
            `REG_STATUS: rdata_d = {io_good_s, reset_low_q, press_s, fault_s,
                                    sys_low_s, hib_high_s, hold_s, wake_q};
            `REG_IRQ_PEND: rdata_d = {6'h00, flt_pend, sys_pend};
            default: rdata_d = 8'h00;
        endcase
    end
end

// Read data stand for one cycle and then return to zero, so a stale value is never seen.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        reg_rdata <= 8'h00;
    end else begin
        reg_rdata <= rdata_d;
    end
end

endmodule // pb_power_sequencer

// >>> rtl/pb_seq_defines.vh
// Constants for the push-button power sequencer: register offsets, fields, resets, timing.
// Assumes a 50 MHz system clock and the plain register port of the sequencer.
`ifndef PB_SEQ_DEFINES_VH
`define PB_SEQ_DEFINES_VH

`define CLK_HZ 50000000
`define CLK_KHZ 50000
// Register offsets on the plain port.
`define REG_CTRL 4'h0
`define REG_IRQ_MASK 4'h1
`define REG_STATUS 4'h2
`define REG_IRQ_PEND 4'h3
// Control register fields.
`define CTRL_FRC_BIT 0
`define CTRL_HIBERNATE_READY_FLAG_BIT 1
`define CTRL_AUXA_BIT 2
`define CTRL_AUXB_BIT 3
`define CTRL_RESET 8'h00
// Interrupt mask fields; a one unmasks.
`define MASK_SYS_BIT 0
`define MASK_FLT_BIT 1
`define MASK_RESET 8'h00
// Sequencing delays in milliseconds, and clock cycles per millisecond.
`define T_CORE_MS 8'h02
`define T_MEM_MS 8'h04
`define T_USB_MS 8'h08
`define MS_CYCLES 24'h00C350
`define RST_TIMEOUT_MS_DEFAULT 16'h0040

`endif

// >>> test/pb_power_sequencer_props.sv
// Checker for the push-button power sequencer, watching the top module's ports only.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ns
module pb_power_sequencer_props (
    input wire clk,
    input wire resetn,
    input wire button_press_in,
    input wire manual_reset_in,
    input wire io_power_good,
    input wire sys_level_status_n,
    input wire fault_in,
    input wire reset_out_n_oe,
    input wire button_status_out_oe,
    input wire interrupt_out_n_oe,
    input wire memory_buck_en,
    input wire io_buck_en,
    input wire core_buck_en,
    input wire oscillator_ldo_en,
    input wire usb_ldo_en,
    input wire aux_ldo_a_en,
    input wire aux_ldo_b_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence press_held;
        (button_press_in || manual_reset_in) [*4];
    endsequence
    sequence press_gone;
        (!button_press_in && !manual_reset_in) [*4];
    endsequence
    a_status_press: assert property (press_held |-> button_status_out_oe) else $error("status idle");
    a_status_idle: assert property (press_gone |-> !button_status_out_oe) else $error("status low");
    a_manual_low: assert property (manual_reset_in [*4] |-> reset_out_n_oe) else $error("no mreset");
    a_irq_quiet: assert property ((!fault_in && !sys_level_status_n) [*4] |-> !interrupt_out_n_oe)
        else $error("irq no cause");
    a_start_low: assert property (!io_power_good [*4] |-> reset_out_n_oe) else $error("early rst");
    a_release_good: assert property ($fell(reset_out_n_oe) |-> $past(io_power_good))
        else $error("rst release");
    a_osc_reset: assert property ($rose(oscillator_ldo_en) |-> reset_out_n_oe && io_buck_en)
        else $error("osc start");
    a_rail_order: assert property ((core_buck_en || usb_ldo_en) |-> io_buck_en && oscillator_ldo_en)
        else $error("rail order");
    a_core_gap: assert property ($rose(core_buck_en) |-> $past(io_buck_en, 5)) else $error("core");
    a_aux_on: assert property ((aux_ldo_a_en || aux_ldo_b_en) |-> memory_buck_en && core_buck_en)
        else $error("aux alone");
endmodule // pb_power_sequencer_props
bind pb_power_sequencer pb_power_sequencer_props u_props (.clk(clk), .resetn(resetn),
    .button_press_in(button_press_in), .manual_reset_in(manual_reset_in),
    .io_power_good(io_power_good), .sys_level_status_n(sys_level_status_n), .fault_in(fault_in),
    .reset_out_n_oe(reset_out_n_oe), .button_status_out_oe(button_status_out_oe),
    .interrupt_out_n_oe(interrupt_out_n_oe), .memory_buck_en(memory_buck_en),
    .io_buck_en(io_buck_en), .core_buck_en(core_buck_en), .oscillator_ldo_en(oscillator_ldo_en),
    .usb_ldo_en(usb_ldo_en), .aux_ldo_a_en(aux_ldo_a_en), .aux_ldo_b_en(aux_ldo_b_en));

// >>> test/host_partner.sv
// Host processor pins and io rail ramp facing the sequencer.
// Assumes the bench asks for hold and wake levels; pins rise only once reset is released.
`timescale 1ns/1ns
module host_partner (
    input wire clk,
    input wire resetn,
    input wire io_buck_en,
    input wire reset_out_n_oe,
    input wire want_hold,
    input wire want_awake,
    output logic power_hold,
    output logic hibernate_low,
    output logic io_power_good
);
    logic [3:0] ramp_q;
    // The rail needs a few cycles to ramp, so power-good never rises with its enable.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramp_q <= 4'h0;
            io_power_good <= 1'b0;
            power_hold <= 1'b0;
            hibernate_low <= 1'b0;
        end else begin
            ramp_q <= {ramp_q[2:0], io_buck_en};
            io_power_good <= ramp_q[3];
            power_hold <= want_hold && (power_hold || !reset_out_n_oe);
            hibernate_low <= want_awake && (hibernate_low || !reset_out_n_oe);
        end
    end
endmodule // host_partner

// >>> test/pb_power_sequencer_tb.sv
// Self-checking bench for the push-button power sequencer.
// Assumes short timing parameters: 10 cycles a millisecond, 2 ms reset timeout.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
`define WAITF(c) for (i = 0; i < 300 && !(c); i++) @(posedge clk);
module pb_power_sequencer_tb;
    localparam int MS = 10;
    localparam int RT = 2;
    logic clk = 0, resetn = 0, button_press_in = 0, manual_reset_in = 0;
    logic sys_level_status_n = 0, fault_in = 0, reg_wr = 0, reg_rd = 0, want_hold = 0;
    logic want_awake = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire power_hold, hibernate_low, io_power_good, rst_oe, st_oe, irq_oe;
    wire memory_buck_en, io_buck_en, core_buck_en, oscillator_ldo_en, usb_ldo_en, aux_a, aux_b;
    wire [4:0] rails = {memory_buck_en, io_buck_en, core_buck_en, oscillator_ldo_en, usb_ldo_en};
    int errors = 0, n_tests = 0, i, tc, tm, tu, tr;
    logic [5:0] rows [6] = '{6'h06, 6'h09, 6'h3F, 6'h2B, 6'h15, 6'h00};
    always #10 clk = ~clk;
    pb_power_sequencer #(.RST_TIMEOUT_MS(RT), .MS_CYCLES(MS)) u_dut (.clk(clk), .resetn(resetn),
        .button_press_in(button_press_in), .manual_reset_in(manual_reset_in),
        .power_hold(power_hold), .hibernate_low(hibernate_low), .io_power_good(io_power_good),
        .sys_level_status_n(sys_level_status_n), .fault_in(fault_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reset_out_n_o(), .reset_out_n_oe(rst_oe), .button_status_out_o(),
        .button_status_out_oe(st_oe), .interrupt_out_n_o(), .interrupt_out_n_oe(irq_oe),
        .memory_buck_en(memory_buck_en), .io_buck_en(io_buck_en), .core_buck_en(core_buck_en),
        .oscillator_ldo_en(oscillator_ldo_en), .usb_ldo_en(usb_ldo_en), .aux_ldo_a_en(aux_a),
        .aux_ldo_b_en(aux_b));
    host_partner u_host (.clk(clk), .resetn(resetn), .io_buck_en(io_buck_en),
        .reset_out_n_oe(rst_oe), .want_hold(want_hold), .want_awake(want_awake),
        .power_hold(power_hold), .hibernate_low(hibernate_low), .io_power_good(io_power_good));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic bit win(input int t, input int tt);
        return t >= (tt - 1) * MS * 88 / 100 && t <= tt * MS * 112 / 100 + 4;
    endfunction
    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(20 * 6000);
        errors++;
        summarize();
    end
    initial begin
        logic [7:0] d;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        wt(3);
        `CHK({rst_oe, rails}, 6'h20)
        rd(4'h1, d); `CHK(d, 8'h00)
        rd(4'h7, d); `CHK(d, 8'h00)
        foreach (rows[k]) begin
            wr(4'h1, {6'h00, rows[k][3:2]});
            @(posedge clk) {fault_in, sys_level_status_n} <= rows[k][1:0];
            wt(5);
            `CHK(irq_oe, |rows[k][5:4])
            rd(4'h3, d); `CHK(d, {6'h00, rows[k][5:4]})
            rd(4'h2, d); `CHK(d, {3'h2, rows[k][1:0], 3'h0})
        end
        // Boot without the host taking over: timing is measured, then the release kills it.
        @(posedge clk) button_press_in <= 1'b1;
        `WAITF(io_power_good)
        {tc, tm, tu, tr} = 0;
        for (int j = 1; j <= 110; j++) begin
            @(posedge clk) #1;
            if (core_buck_en && tc == 0) tc = j;
            if (memory_buck_en && tm == 0) tm = j;
            if (usb_ldo_en && tu == 0) tu = j;
            if (!rst_oe && tr == 0) tr = j;
            if (j == 5) `CHK(oscillator_ldo_en & rst_oe, 1'b1)
        end
        `CHK({win(tc, 2), win(tm, 4), win(tu, 8)}, 3'h7)
        `CHK(tc < tm && tm < tu, 1'b1)
        `CHK(tr >= RT * MS && tr <= RT * MS + 4, 1'b1)
        @(posedge clk) button_press_in <= 1'b0;
        wt(6); `CHK(rails, 5'h00)
        `WAITF(!io_power_good)
        // Full boot with the host holding the rails.
        @(posedge clk) {want_hold, want_awake, button_press_in} <= 3'h7;
        `WAITF(io_power_good && !rst_oe)
        wt(4);
        @(posedge clk) button_press_in <= 1'b0;
        wt(6); `CHK(rails, 5'h1F)
        wr(4'h0, 8'h0C);
        wt(3); `CHK({aux_a, aux_b}, 2'h3)
        rd(4'h0, d); `CHK(d, 8'h0C)
        @(posedge clk) button_press_in <= 1'b1;
        wt(5); `CHK({st_oe, rst_oe}, 2'h2)
        @(posedge clk) manual_reset_in <= 1'b1;
        wt(5); `CHK(rst_oe, 1'b1)
        @(posedge clk) {manual_reset_in, button_press_in} <= 2'h0;
        wt(RT * MS - 8); `CHK(rst_oe, 1'b1)
        wt(13); `CHK(rst_oe, 1'b0)
        // Hibernate, memory rail forced, then wake and shut down.
        wr(4'h0, 8'h03);
        @(posedge clk) want_awake <= 1'b0;
        wt(8); `CHK(rails, 5'h10)
        @(posedge clk) want_hold <= 1'b0;
        wt(8); `CHK(rails, 5'h10)
        @(posedge clk) button_press_in <= 1'b1;
        `WAITF(io_power_good)
        wt(6); `CHK(rails, 5'h1F)
        `WAITF(!rst_oe)
        `CHK(rst_oe, 1'b0)
        @(posedge clk) {want_hold, want_awake} <= 2'h3;
        rd(4'h0, d); `CHK(d[1], 1'b1)
        wt(6);
        @(posedge clk) button_press_in <= 1'b0;
        wr(4'h0, 8'h00);
        wt(6); `CHK(rails, 5'h1F)
        @(posedge clk) {want_hold, want_awake} <= 2'h0;
        wt(8); `CHK(rails, 5'h00)
        summarize();
    end
endmodule // pb_power_sequencer_tb
